//--- hw/mii_4b5b_link_bridge.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// RULE_01 - external-MAC mode routes control traffic through this nibble port, not internal links.
// RULE_02 - MAC drives and samples the port on the core clock itself.
// RULE_03 - each accepted data nibble becomes a 4B/5B symbol for the framer.
// RULE_04 - transmit nibbles accepted only after frame sync; ready output shows acceptance.
// RULE_05 - ready drops the cycle after any take; may stay low for back-pressure.
// RULE_06 - MAC holds transmit nibble steady while ready is low.
// RULE_07 - MAC raises enable, usually one cycle after ready rises.
// RULE_08 - first enabled cycle queues J, second queues K; nibble ignored in both.
// RULE_09 - ready high without enable after its first cycle queues Idle each cycle.
// RULE_10 - enable low in a ready cycle mid-packet ends frame: queue T then R.
// RULE_11 - after the T and R pair, ready is withdrawn.
// RULE_12 - enable with error in one cycle queues HALT instead of the nibble.
// RULE_13 - MAC may hold enable whole packet or drop it between nibbles.
// RULE_14 - MAC must re-raise enable when ready returns, else T ends packet.
// RULE_15 - received symbols decode into nibbles on the receive data output.
// RULE_16 - receive data goes out only after frame sync.
// RULE_17 - J consumed internally; output starts with K nibble then packet data.
// RULE_18 - receive valid high over K and data, low once frame delivered.
// RULE_19 - write strobe pulses in the first cycle of each new nibble.
// RULE_20 - receive error high while frame sync is absent.
// RULE_21 - received HALT decodes to an all-ones nibble.
// RULE_22 - reset or sync loss idles both paths and discards any partial packet.
//////////////////////////////////////////////////////////////////////////////
module mii_4b5b_link_bridge #(
    parameter int QDEPTH = mii_bridge_pkg::TXQ_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // link status and mode
    input wire logic frame_sync,
    input wire logic ext_mac_mode,
    output logic bypass_active,
    // nibble port, transmit direction
    output logic tx_ready,
    input wire logic tx_enable,
    input wire logic tx_error,
    input wire logic [3:0] tx_nibble,
    // symbols to the link framer
    output logic link_tx_valid,
    output logic [4:0] link_tx_sym,
    input wire logic link_tx_ready,
    // symbols from the link framer
    input wire logic link_rx_valid,
    input wire logic [4:0] link_rx_sym,
    // nibble port, receive direction
    output logic [3:0] rx_nibble,
    output logic rx_valid,
    output logic rx_write,
    output logic rx_error
);
    import mii_bridge_pkg::*;

    generate
        if (QDEPTH < 2) begin : g_bad_qdepth
            $error("transmit queue needs room for the T and R pair");
        end
    endgenerate

    bridge_t s;
    bridge_t next_s;
    logic live;
    logic take;
    logic push;
    logic [4:0] push_sym;
    logic q_full;

    //////////////////////////////////////////////////////////////////////////
    // transmit handshake

    assign live = frame_sync && ext_mac_mode; // RULE_01
    // the queue never overfills because ready already counts its room
    assign tx_ready = live && !q_full && !s.took && (s.tx != TX_OFF); // RULE_04 RULE_05
    assign take = tx_ready && tx_enable;

    //////////////////////////////////////////////////////////////////////////
    // next state of both paths

    always_comb begin
        next_s = s;
        push = 1'b0;
        push_sym = SYM_IDLE;
        next_s.took = take; // RULE_05
        next_s.bypass = ext_mac_mode; // RULE_01
        next_s.rxwr = 1'b0;
        next_s.rxer = !frame_sync; // RULE_20

        unique case (s.tx)
            TX_OFF: begin
                next_s.first = 1'b1;
                if (live) begin
                    next_s.tx = TX_ARMED;
                end
            end
            TX_ARMED: begin
                if (tx_ready) begin
                    next_s.first = 1'b0;
                    if (tx_enable) begin
                        push = 1'b1;
                        push_sym = SYM_J; // RULE_08
                        next_s.tx = TX_SOF;
                    end else if (!s.first) begin
                        push = 1'b1;
                        push_sym = SYM_IDLE; // RULE_09
                    end
                end
            end
            TX_SOF: begin
                if (tx_ready) begin
                    push = 1'b1;
                    if (tx_enable) begin
                        push_sym = SYM_K; // RULE_08
                        next_s.tx = TX_DATA;
                    end else begin
                        push_sym = SYM_T; // RULE_14
                        next_s.tx = TX_EOP;
                    end
                end
            end
            TX_DATA: begin
                // enable may stay high or drop between nibbles; only ready cycles count
                if (tx_ready) begin // RULE_13
                    push = 1'b1;
                    if (tx_enable && tx_error) begin
                        push_sym = SYM_HALT; // RULE_12
                    end else if (tx_enable) begin
                        push_sym = encode_nibble(tx_nibble); // RULE_03
                    end else begin
                        push_sym = SYM_T; // RULE_10 RULE_14
                        next_s.tx = TX_EOP;
                    end
                end
            end
            TX_EOP: begin
                if (tx_ready) begin
                    push = 1'b1;
                    push_sym = SYM_R; // RULE_10
                    next_s.tx = TX_OFF; // RULE_11
                end
            end
        endcase

        // receive path
        if (!live) begin
            next_s.rx = RX_HUNT; // RULE_16 RULE_22
            next_s.rxdv = 1'b0;
        end else if (link_rx_valid) begin
            unique case (s.rx)
                RX_HUNT: begin
                    if (link_rx_sym == SYM_J) begin
                        next_s.rx = RX_GOTJ; // RULE_17
                    end
                end
                RX_GOTJ: begin
                    if (link_rx_sym == SYM_K) begin
                        next_s.rx = RX_FRAME;
                        next_s.rxd = NIB_K; // RULE_17
                        next_s.rxdv = 1'b1; // RULE_18
                        next_s.rxwr = 1'b1; // RULE_19
                    end else begin
                        next_s.rx = RX_HUNT;
                    end
                end
                RX_FRAME: begin
                    // T or a bare idle closes the frame; R then falls into hunt
                    if (link_rx_sym == SYM_T || link_rx_sym == SYM_IDLE) begin
                        next_s.rx = RX_HUNT;
                        next_s.rxdv = 1'b0; // RULE_18
                    end else begin
                        next_s.rxd = decode_symbol(link_rx_sym); // RULE_15 RULE_21
                        next_s.rxwr = 1'b1; // RULE_19
                    end
                end
            endcase
        end

        // losing sync abandons the transmit packet as well
        if (!live) begin
            next_s.tx = TX_OFF; // RULE_22
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            s <= BRIDGE_RESET; // RULE_22
        end else begin
            s <= next_s;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // transmit symbol queue toward the framer

    sym_queue #(
        .WIDTH(5),
        .DEPTH(QDEPTH)
    ) u_txq (
        .mclk(mclk),
        .rst_b(rst_b),
        .flush(!live),
        .push(push),
        .push_data(push_sym),
        .full(q_full),
        .out_valid(link_tx_valid),
        .out_data(link_tx_sym),
        .out_ready(link_tx_ready)
    );

    assign bypass_active = s.bypass;
    assign rx_nibble = s.rxd;
    assign rx_valid = s.rxdv;
    assign rx_write = s.rxwr;
    assign rx_error = s.rxer;

    //////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    sequence s_taken;
        tx_ready && tx_enable;
    endsequence

    sequence s_frame_end;
        s.tx == TX_DATA && tx_ready && !tx_enable;
    endsequence

    sequence s_push_r;
        push && push_sym == SYM_R;
    endsequence

    AST_READY_DROPS: assert property (s_taken |=> !tx_ready) // RULE_05
        else $error("ready stayed high after a take");

    AST_NO_SYNC_NO_READY: assert property (!frame_sync |-> !tx_ready) // RULE_04
        else $error("ready high without frame sync");

    AST_J_THEN_K: assert property (s.tx == TX_ARMED ##0 s_taken |-> push && push_sym == SYM_J // RULE_08
                                   ##1 (s.tx == TX_SOF && !tx_ready))
        else $error("start of packet did not queue J");

    AST_K_SECOND: assert property (s.tx == TX_SOF ##0 s_taken |-> push && push_sym == SYM_K) // RULE_08
        else $error("second enabled cycle did not queue K");

    AST_IDLE_FILL: assert property (s.tx == TX_ARMED && tx_ready && !tx_enable && !s.first // RULE_09
                                    |-> push && push_sym == SYM_IDLE)
        else $error("idle not queued while waiting for enable");

    AST_END_T: assert property (s_frame_end |-> push && push_sym == SYM_T ##1 s.tx == TX_EOP) // RULE_10
        else $error("end of frame did not queue T");

    AST_R_STOPS_READY: assert property (s_push_r |=> !tx_ready ##1 s.tx != TX_EOP) // RULE_11
        else $error("ready not withdrawn after R");

    AST_HALT_TX: assert property (s.tx == TX_DATA && take && tx_error |-> push && push_sym == SYM_HALT) // RULE_12
        else $error("error nibble not replaced by halt");

    AST_ENCODE: assert property (s.tx == TX_DATA && take && !tx_error // RULE_03
                                 |-> push && push_sym == CODE_TABLE[tx_nibble])
        else $error("data nibble mis-encoded");

    AST_RX_K_START: assert property (live && link_rx_valid && s.rx == RX_GOTJ // RULE_17 RULE_18
                                     && link_rx_sym == SYM_K |=> rx_valid && rx_write && rx_nibble == NIB_K)
        else $error("frame did not open with the K nibble");

    AST_RX_HALT: assert property (live && link_rx_valid && s.rx == RX_FRAME // RULE_21
                                  && link_rx_sym == SYM_HALT |=> rx_write && rx_nibble == NIB_ERR && rx_valid)
        else $error("received halt not shown as all ones");

    AST_RX_ERROR: assert property (!frame_sync |=> rx_error) // RULE_20
        else $error("receive error low without sync");

    AST_SYNC_LOSS: assert property (!live |=> !rx_valid && !rx_write && !tx_ready) // RULE_16 RULE_22
        else $error("paths not idled after sync loss");

    AST_RX_END: assert property (live && link_rx_valid && s.rx == RX_FRAME // RULE_18
                                 && link_rx_sym == SYM_T |=> !rx_valid && !rx_write)
        else $error("receive valid not dropped at frame end");

    // a queued symbol always answers a ready cycle the MAC could see
    AST_NO_PUSH_UNREADY: assert property (!tx_ready |-> !push) // RULE_04
        else $error("symbol queued while ready was low");

    // the first ready cycle gives the MAC one chance before idles start
    AST_FIRST_READY_QUIET: assert property (s.tx == TX_ARMED && s.first && tx_ready // RULE_09
                                            && !tx_enable |-> !push)
        else $error("idle queued in the first ready cycle");

    AST_RX_WRITE: assert property (live && link_rx_valid && s.rx == RX_FRAME && link_rx_sym != SYM_T // RULE_19
                                   && link_rx_sym != SYM_IDLE |=> rx_write && rx_valid)
        else $error("frame symbol gave no write strobe");

    AST_T_THEN_R: assert property (s.tx == TX_EOP && tx_ready |-> push && push_sym == SYM_R) // RULE_10
        else $error("R did not follow T");

    AST_BYPASS_ON: assert property (ext_mac_mode |=> bypass_active) // RULE_01
        else $error("bypass not reported in external-MAC mode");

    AST_BYPASS_OFF: assert property (!ext_mac_mode |=> !bypass_active) // RULE_01
        else $error("bypass reported outside external-MAC mode");

    AST_RX_ERROR_CLEARS: assert property (frame_sync |=> !rx_error) // RULE_20
        else $error("receive error high with sync present");

endmodule // mii_4b5b_link_bridge

//--- hw/mii_bridge_pkg.sv
package mii_bridge_pkg;

    // 4B/5B control symbols
    localparam logic [4:0] SYM_J = 5'h18;
    localparam logic [4:0] SYM_K = 5'h11;
    localparam logic [4:0] SYM_T = 5'h0D;
    localparam logic [4:0] SYM_R = 5'h07;
    localparam logic [4:0] SYM_IDLE = 5'h1F;
    localparam logic [4:0] SYM_HALT = 5'h04;

    // nibbles shown on the receive side
    localparam logic [3:0] NIB_K = 4'h5;
    localparam logic [3:0] NIB_ERR = 4'hF;

    // default depth of the transmit symbol queue
    localparam int TXQ_DEPTH = 4;

    typedef enum logic [4:0] {
        TX_OFF = 5'b00001,
        TX_ARMED = 5'b00010,
        TX_SOF = 5'b00100,
        TX_DATA = 5'b01000,
        TX_EOP = 5'b10000
    } tx_state_t;

    typedef enum logic [2:0] {
        RX_HUNT = 3'b001,
        RX_GOTJ = 3'b010,
        RX_FRAME = 3'b100
    } rx_state_t;

    typedef struct packed {
        tx_state_t tx;
        logic took;
        logic first;
        rx_state_t rx;
        logic [3:0] rxd;
        logic rxdv;
        logic rxwr;
        logic rxer;
        logic bypass;
    } bridge_t;

    // receive error stands high until sync is seen
    localparam bridge_t BRIDGE_RESET = '{tx: TX_OFF, took: 1'b0, first: 1'b1, rx: RX_HUNT, rxd: 4'h0,
                                         rxdv: 1'b0, rxwr: 1'b0, rxer: 1'b1, bypass: 1'b0};

    localparam logic [15:0][4:0] CODE_TABLE = {
        5'h1D, 5'h1C, 5'h1B, 5'h1A, 5'h17, 5'h16, 5'h13, 5'h12,
        5'h0F, 5'h0E, 5'h0B, 5'h0A, 5'h15, 5'h14, 5'h09, 5'h1E
    };

    function automatic logic [4:0] encode_nibble(input logic [3:0] nib);
        return CODE_TABLE[nib];
    endfunction

    // unknown symbols decode as all ones, same as a halt
    function automatic logic [3:0] decode_symbol(input logic [4:0] sym);
        logic [3:0] nib;
        nib = NIB_ERR;
        for (int i = 0; i < 16; i++) begin
            if (CODE_TABLE[i] == sym) begin
                nib = 4'(i);
            end
        end
        return nib;
    endfunction

endpackage

//--- hw/sym_queue.sv
`timescale 1ns/1ps
module sym_queue #(
    parameter int WIDTH = 5,
    parameter int DEPTH = mii_bridge_pkg::TXQ_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // fill side
    input wire logic flush,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic full,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    import mii_bridge_pkg::*;

    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("sym_queue depth must be a power of two, at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic dv;
        logic [WIDTH-1:0] dout;
    } queue_t;

    queue_t q;
    queue_t next_q;
    logic load;

    always_comb begin
        next_q = q;
        load = (q.cnt != '0) && (!q.dv || out_ready);
        if (load) begin
            next_q.dout = q.mem[q.rd];
            next_q.rd = q.rd + 1'b1;
            next_q.dv = 1'b1;
        end else if (out_ready) begin
            next_q.dv = 1'b0;
        end
        if (push) begin
            next_q.mem[q.wr] = push_data;
            next_q.wr = q.wr + 1'b1;
        end
        next_q.cnt = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        // a lost link drops whatever partial packet was queued
        if (flush) begin
            next_q = '0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign full = (q.cnt == (AW + 1)'(DEPTH));
    assign out_valid = q.dv;
    assign out_data = q.dout;

    AST_Q_NO_OVERFLOW: assert property (@(posedge mclk) disable iff (!rst_b) full |-> !push) // RULE_05
        else $error("symbol pushed into a full queue");

endmodule // sym_queue

//--- test/mac_model.sv
`timescale 1ns/1ps
module mac_model (
    // clock, reset and test control
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [31:0] pkt,
    input wire logic [3:0] len,
    input wire logic [3:0] dly,
    input wire logic [3:0] err,
    input wire logic pulse,
    // nibble port
    input wire logic tx_ready,
    output logic tx_enable,
    output logic tx_error,
    output logic [3:0] tx_nibble
);
    int took = 0;
    int waited = 0;
    int idx;
    always @(posedge mclk) begin
        if (!rst_b || !start) begin
            took = 0;
            waited = 0;
        end else if (tx_ready === 1'b1) begin
            if (tx_enable) took++;
            else if (took == 0) waited++;
        end
        #1;
        idx = (took < 2) ? 0 : ((took > 9) ? 7 : took - 2);
        // nibble moves only after a take, so it stands through back-pressure
        tx_nibble = pkt[4*idx +: 4];
        tx_error = (took >= 2) && (idx == err);
        // pulse style drops enable while ready is low and raises it again with ready
        tx_enable = rst_b && start && (waited >= dly) && (took < len + 2)
            && (!pulse || tx_ready === 1'b1);
    end
endmodule // mac_model

//--- test/mii_4b5b_link_bridge_bench.sv
`timescale 1ns/1ps
module mii_4b5b_link_bridge_bench;
    import mii_bridge_pkg::*;
    localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                                        5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic frame_sync = 1'b1;
    logic ext_mac_mode = 1'b1;
    logic link_tx_ready = 1'b1;
    logic link_rx_valid = 1'b0;
    logic [4:0] link_rx_sym = 5'h00;
    logic start = 1'b0;
    logic [31:0] pkt = 32'h0;
    logic [3:0] len = 4'h1;
    logic [3:0] dly = 4'h0;
    logic [3:0] err = 4'hF;
    logic pulse = 1'b0;
    logic bypass_active, tx_ready, tx_enable, tx_error, link_tx_valid, rx_valid, rx_write, rx_error;
    logic [3:0] tx_nibble;
    logic [3:0] rx_nibble;
    logic [4:0] link_tx_sym;
    logic [4:0] got_q[$];
    logic [4:0] exp_q[$];
    logic took_prev = 1'b0;
    int n_mismatch = 0;
    int n_checks = 0;
    logic [3:0] nb;

    always #10 mclk = ~mclk;

    mii_4b5b_link_bridge DUT (.mclk(mclk), .rst_b(rst_b), .frame_sync(frame_sync), .ext_mac_mode(ext_mac_mode),
        .bypass_active(bypass_active), .tx_ready(tx_ready), .tx_enable(tx_enable), .tx_error(tx_error),
        .tx_nibble(tx_nibble), .link_tx_valid(link_tx_valid), .link_tx_sym(link_tx_sym),
        .link_tx_ready(link_tx_ready), .link_rx_valid(link_rx_valid), .link_rx_sym(link_rx_sym),
        .rx_nibble(rx_nibble), .rx_valid(rx_valid), .rx_write(rx_write), .rx_error(rx_error));

    mac_model mac (.mclk(mclk), .rst_b(rst_b), .start(start), .pkt(pkt), .len(len), .dly(dly), .err(err),
        .pulse(pulse), .tx_ready(tx_ready), .tx_enable(tx_enable), .tx_error(tx_error), .tx_nibble(tx_nibble));

    //////////////////////////////////////////////////////////////////////////////
    task automatic chk_sym(input string what, input logic [4:0] exp, input logic [4:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic reset_dut();
        @(posedge mclk);
        #1 rst_b = 1'b0;
        start = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk_val("tx_ready in reset", 4'h0, 4'(tx_ready));
        chk_val("rx_valid in reset", 4'h0, 4'(rx_valid));
        rst_b = 1'b1;
    endtask

    function automatic void build_tx(input logic [31:0] p, input int n, input int d, input int e);
        exp_q.delete();
        for (int i = 1; i < d; i++) exp_q.push_back(SYM_IDLE);
        exp_q.push_back(SYM_J);
        exp_q.push_back(SYM_K);
        for (int i = 0; i < n; i++) exp_q.push_back((i == e) ? SYM_HALT : ENC[p[4*i +: 4]]);
        exp_q.push_back(SYM_T);
        exp_q.push_back(SYM_R);
    endfunction

    task automatic tx_test(input int n, input int d, input int e);
        reset_dut();
        pkt = $urandom();
        len = 4'(n);
        dly = 4'(d);
        err = 4'(e);
        pulse = 1'(n % 2);
        build_tx(pkt, n, d, e);
        got_q.delete();
        start = 1'b1;
        for (int w = 0; w < 400 && got_q.size() < exp_q.size(); w++) @(posedge mclk);
        #1 chk_val("symbol count", 4'h1, 4'(got_q.size() >= exp_q.size()));
        for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
            chk_sym("link_tx_sym", exp_q[i], got_q[i]);
        end
        $display("tx test len %0d delay %0d error at %0d pulse %0d done", n, d, e, pulse);
    endtask

    // framer sink stalls at random; one take must always be followed by a low ready
    always @(posedge mclk) begin
        if (link_tx_valid === 1'b1 && link_tx_ready === 1'b1) got_q.push_back(link_tx_sym);
        if (took_prev) chk_val("tx_ready after take", 4'h0, 4'(tx_ready));
        took_prev = rst_b && (tx_ready === 1'b1) && (tx_enable === 1'b1);
        #1 link_tx_ready = (($urandom() % 4) != 0);
    end

    task automatic rx_sym(input logic [4:0] s, input logic [3:0] nib, input logic dv, input logic wr);
        link_rx_valid = 1'b1;
        link_rx_sym = s;
        @(posedge mclk);
        // released symbol line shows the inverse, never the old value
        #1 link_rx_valid = 1'b0;
        link_rx_sym = ~s;
        chk_val("rx_valid", 4'(dv), 4'(rx_valid));
        chk_val("rx_write", 4'(wr), 4'(rx_write));
        if (wr) chk_val("rx_nibble", nib, rx_nibble);
        @(posedge mclk);
        #1 chk_val("rx_write gap", 4'h0, 4'(rx_write));
    endtask

    //////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'hd0b2));
        repeat (6) @(posedge mclk);
        #1 rst_b = 1'b1;
        tx_test(1, 0, 15);
        tx_test(8, 1, 0);
        tx_test(3, 3, 2);
        repeat (5) tx_test(1 + $urandom() % 8, $urandom() % 4, $urandom() % 10);
        reset_dut();
        rx_sym(SYM_K, 4'h0, 1'b0, 1'b0);
        rx_sym(SYM_J, 4'h0, 1'b0, 1'b0);
        rx_sym(SYM_K, NIB_K, 1'b1, 1'b1);
        for (int i = 0; i < 4; i++) begin
            nb = 4'($urandom());
            rx_sym(ENC[nb], nb, 1'b1, 1'b1);
        end
        rx_sym(SYM_HALT, NIB_ERR, 1'b1, 1'b1);
        rx_sym(SYM_T, 4'h0, 1'b0, 1'b0);
        rx_sym(SYM_J, 4'h0, 1'b0, 1'b0);
        rx_sym(SYM_K, NIB_K, 1'b1, 1'b1);
        frame_sync = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk_val("rx_error no sync", 4'h1, 4'(rx_error));
        chk_val("rx_valid sync lost", 4'h0, 4'(rx_valid));
        chk_val("tx_ready no sync", 4'h0, 4'(tx_ready));
        chk_val("bypass_active", 4'h1, 4'(bypass_active));
        rx_sym(SYM_J, 4'h0, 1'b0, 1'b0);
        rx_sym(SYM_K, 4'h0, 1'b0, 1'b0);
        frame_sync = 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk_val("rx_error in sync", 4'h0, 4'(rx_error));
        ext_mac_mode = 1'b0;
        repeat (2) @(posedge mclk);
        #1 chk_val("bypass_active off", 4'h0, 4'(bypass_active));
        chk_val("tx_ready mode off", 4'h0, 4'(tx_ready));
        $display("rx and sync test done");
        give_verdict();
    end

    // the tests take a few hundred cycles; twenty thousand means a hang
    initial begin
        #400000;
        n_mismatch++;
        give_verdict();
    end
endmodule // mii_4b5b_link_bridge_bench
